// ### hdl/fambm_pkg.sv
/*
 * Shared constants for the queue access and buffer move interpreter:
 * instruction codes, interpreter states, widths and reset values.
 * Assumes a byte-level front end that decodes the serial instruction.
 */
package fambm_pkg;

    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 12;
    localparam int CNT_W     = 8;
    localparam int TXQ_DEPTH = 8;
    localparam int NUM_SLOTS = 2;

    localparam logic [DATA_W-1:0] FIRST_OCCUPANCY = 8'h00;
    localparam logic [DATA_W-1:0] RESP_RESET      = 8'h00;
    localparam logic [DATA_W-1:0] EMPTY_READ      = 8'h00;
    localparam logic [CNT_W-1:0]  LAST_BYTE       = 8'h01;
    localparam logic [CNT_W-1:0]  NO_BYTES        = 8'h00;
    localparam logic [DATA_W-1:0] NOISE_SEED      = 8'h01;
    localparam logic [5:0]        STATUS_PAD      = 6'h00;
    localparam logic [ADDR_W-1:0] MEM_LIMIT_DEF   = 12'hfff;

    typedef enum logic [1:0] {
        INSTR_APPEND    = 2'h0,
        INSTR_RANDOM    = 2'h1,
        INSTR_MOVE      = 2'h2,
        INSTR_READ_COPY = 2'h3
    } fambm_instr_type;

    typedef enum logic [4:0] {
        ST_IDLE       = 5'h01,
        ST_APPEND     = 5'h02,
        ST_RANDOM     = 5'h04,
        ST_COPY_COUNT = 5'h08,
        ST_COPY_DATA  = 5'h10
    } fambm_state_type;

endpackage : fambm_pkg

// ### hdl/fambm_fifo.sv
/*
 * Transmit queue: synchronous FIFO, valid/ready on both sides, with count.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module fambm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_in_valid,
    input  wire logic [WIDTH-1:0]           i_in_data,
    output logic                            o_in_ready,
    output logic                            o_out_valid,
    output logic [WIDTH-1:0]                o_out_data,
    input  wire logic                       i_out_ready,
    output logic [$clog2(DEPTH+1)-1:0]      o_count
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("fambm_fifo: DEPTH must be at least 2");
        end
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [CW-1:0]    cnt_q;
    logic             out_valid_q;
    logic [WIDTH-1:0] out_data_q;
    wire              push = i_in_valid && o_in_ready;
    wire              pop  = o_out_valid && i_out_ready;
    wire [PW-1:0]     wr_nx = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    wire [PW-1:0]     rd_nx = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    // Head after this edge: a stored word, or the pushed one if none is left
    wire [PW-1:0]     rd_d  = pop ? rd_nx : rd_q;
    wire              rest  = pop ? (cnt_q > CW'(1)) : (cnt_q != '0);

    assign o_in_ready  = (cnt_q != CW'(DEPTH));
    assign o_out_valid = out_valid_q;
    assign o_out_data  = out_data_q;
    assign o_count     = cnt_q;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else begin
            out_valid_q <= rest || push;
            out_data_q  <= rest ? mem_q[rd_d] : i_in_data;
            if (push) begin
                wr_q <= wr_nx;
            end
            if (pop) begin
                rd_q <= rd_nx;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule : fambm_fifo

// ### hdl/fambm_noise_byte.sv
/*
 * Random byte source: folds a receiver noise bit into an 8-bit LFSR.
 * Assumes the noise bit comes from logic on the same clock.
 */
`timescale 1ns/1ns
module fambm_noise_byte (
    input  wire logic                        i_clk,
    input  wire logic                        i_reset,
    input  wire logic                        i_noise_bit,
    output logic [fambm_pkg::DATA_W-1:0]     o_value
);

    logic [fambm_pkg::DATA_W-1:0] lfsr_q;
    wire                          fb = lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4]
                                     ^ lfsr_q[3] ^ i_noise_bit;

    assign o_value = lfsr_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lfsr_q <= fambm_pkg::NOISE_SEED;
        end else begin
            lfsr_q <= {lfsr_q[6:0], fb};
        end
    end

endmodule : fambm_noise_byte

// ### hdl/fambm_core.sv
/*
 * Instruction interpreter for transmit queue append, random read,
 * receive queue read-and-copy and prioritised receive queue moves.
 * Assumes a byte front end on the same clock, an external receive
 * queue that pops one cycle after o_rxq_pop, and a memory write port.
 */
// Operation
// RULE1: Host avoids read-and-copy while a move runs; copy then wins.
// RULE2: Append bytes after the opcode to the transmit queue tail.
// RULE3: Each append byte answers occupancy before the push; first is zero.
// RULE4: Append into a full transmit queue raises overflow.
// RULE5: Random read returns status then one fresh noise byte per transfer.
// RULE6: Move count oldest receive bytes into memory from start address.
// RULE7: Priority operand zero selects low slot, one selects high slot.
// RULE8: Receive queue empty before completion raises move timeout. With timeout control set, the code waits for i_frame_done before raising it.
// RULE9: Remaining count of an unfinished move is readable.
// RULE10: High move with timeout control set blocks other unit work.
// RULE11: Every ended move raises its priority's done event.
// RULE12: Move request to an active slot raises slot busy.
// RULE13: Read-and-copy pops bytes to host and writes them to memory.
// RULE14: Low and high slots hold one pending move each.
`timescale 1ns/1ns
module fambm_core #(
    parameter int                  TXQ_DEPTH = fambm_pkg::TXQ_DEPTH,
    parameter logic [11:0]         MEM_LIMIT = fambm_pkg::MEM_LIMIT_DEF
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic              i_instr_start,
    input  wire logic [1:0]        i_instr_code,
    input  wire logic              i_instr_end,
    input  wire logic              i_byte_valid,
    input  wire logic [7:0]        i_byte_data,
    input  wire logic              i_move_prio,
    input  wire logic [11:0]       i_move_addr,
    input  wire logic [7:0]        i_move_count,
    input  wire logic [11:0]       i_copy_addr,
    input  wire logic              i_rx_timeout_ctrl,
    input  wire logic              i_frame_done,
    input  wire logic              i_noise_bit,
    input  wire logic              i_rxq_valid,
    input  wire logic [7:0]        i_rxq_data,
    input  wire logic [7:0]        i_rxq_count,
    output logic                   o_rxq_pop,
    output logic                   o_txq_valid,
    output logic [7:0]             o_txq_data,
    input  wire logic              i_txq_ready,
    output logic                   o_mem_we,
    output logic [11:0]            o_mem_addr,
    output logic [7:0]             o_mem_wdata,
    output logic                   o_resp_valid,
    output logic [7:0]             o_resp_data,
    output logic [7:0]             o_move_remaining,
    output logic                   o_dpu_blocked,
    output logic                   o_tx_overflow_exc,
    output logic                   o_move_timeout_exc,
    output logic                   o_low_prio_done_exc,
    output logic                   o_high_prio_done_exc,
    output logic                   o_slot_busy_exc,
    output logic                   o_bad_operand_exc,
    output logic                   o_bad_address_exc
);

    localparam int CW = $clog2(TXQ_DEPTH + 1);

    initial begin
        if (TXQ_DEPTH < 2 || TXQ_DEPTH > 255) begin
            $error("fambm_core: TXQ_DEPTH must lie in 2..255");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    fambm_pkg::fambm_state_type state_q;
    fambm_pkg::fambm_state_type state_d;
    logic [11:0]   copy_addr_q;
    logic          pop_wait_q;
    logic [1:0]    act_q;
    logic [1:0]    tim_q;
    logic [11:0]   addr_q [2];
    logic [7:0]    cnt_q  [2];
    logic          rxq_pop_q;
    logic          mem_we_q;
    logic [11:0]   mem_addr_q;
    logic [7:0]    mem_wdata_q;
    logic          resp_valid_q;
    logic [7:0]    resp_data_q;
    logic [7:0]    remaining_q;
    logic          blocked_q;
    logic [6:0]    exc_q;
    logic          txq_in_ready;
    logic [CW-1:0] txq_count;
    logic [7:0]    rand_value;

    ////////////////////////////////////////////////////////////////////////
    // Instruction decode

    wire st_append = (state_q == fambm_pkg::ST_APPEND);
    wire st_random = (state_q == fambm_pkg::ST_RANDOM);
    wire st_ccount = (state_q == fambm_pkg::ST_COPY_COUNT);
    wire st_cdata  = (state_q == fambm_pkg::ST_COPY_DATA);
    wire is_move   = i_instr_start &&
                     (i_instr_code == fambm_pkg::INSTR_MOVE);
    wire [7:0] status_byte = {fambm_pkg::STATUS_PAD, act_q[1], act_q[0]};
    wire [7:0] occupancy   = 8'(txq_count);

    wire append_byte = i_byte_valid && st_append && !i_instr_start;
    wire txq_push    = append_byte && txq_in_ready;           // RULE2
    wire tx_overflow = append_byte && !txq_in_ready;          // RULE4
    wire rand_byte   = i_byte_valid && st_random && !i_instr_start;
    wire ccount_byte = i_byte_valid && st_ccount && !i_instr_start;
    wire cdata_byte  = i_byte_valid && st_cdata && !i_instr_start;
    wire copy_take   = cdata_byte && i_rxq_valid && !pop_wait_q; // RULE1

    ////////////////////////////////////////////////////////////////////////
    // Move request checks

    wire [12:0] move_last = {1'b0, i_move_addr} + {5'h00, i_move_count}
                            - 13'h0001;
    wire req_busy  = is_move && act_q[i_move_prio];            // RULE12
    wire req_opnd  = is_move && !req_busy &&
                     (i_move_count == fambm_pkg::NO_BYTES);
    wire req_addr  = is_move && !req_busy && !req_opnd &&
                     (move_last > {1'b0, MEM_LIMIT});
    wire req_ok    = is_move && !req_busy && !req_opnd && !req_addr;

    ////////////////////////////////////////////////////////////////////////
    // Move engine: high slot is served before low slot

    wire       eng_sel  = act_q[1];                             // RULE7
    wire       eng_act  = act_q[eng_sel];
    wire [7:0] eng_cnt  = cnt_q[eng_sel];
    wire       eng_can  = eng_act && !pop_wait_q && !copy_take; // RULE1
    wire       eng_step = eng_can && i_rxq_valid;               // RULE6
    wire       eng_to   = eng_can && !i_rxq_valid &&
                          (!tim_q[eng_sel] || i_frame_done);    // RULE8
    wire       eng_last = eng_step && (eng_cnt == fambm_pkg::LAST_BYTE);
    wire       eng_fin  = eng_to || eng_last;
    wire       pop_now  = eng_step || copy_take;

    genvar s;
    generate
        for (s = 0; s < fambm_pkg::NUM_SLOTS; s++) begin : g_slot
            wire load = req_ok && (i_move_prio == 1'(s));      // RULE14
            wire step = eng_step && (eng_sel == 1'(s));
            wire fin  = eng_fin && (eng_sel == 1'(s));
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    act_q[s]  <= 1'b0;
                    tim_q[s]  <= 1'b0;
                    addr_q[s] <= '0;
                    cnt_q[s]  <= '0;
                end else if (load) begin
                    act_q[s]  <= 1'b1;
                    tim_q[s]  <= i_rx_timeout_ctrl;
                    addr_q[s] <= i_move_addr;
                    cnt_q[s]  <= i_move_count;
                end else begin
                    if (step) begin
                        addr_q[s] <= addr_q[s] + 12'h001;
                        cnt_q[s]  <= cnt_q[s] - 8'h01;
                    end
                    if (fin) begin
                        act_q[s] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next values

    wire [11:0] mem_addr_d  = copy_take ? copy_addr_q : addr_q[eng_sel];
    wire        blocked_d   = act_q[1] && tim_q[1];             // RULE10
    wire [7:0]  remaining_d = eng_to ? eng_cnt : fambm_pkg::NO_BYTES;
    wire [6:0]  exc_d = {req_addr, req_opnd, req_busy,
                         eng_fin && eng_sel,                    // RULE11
                         eng_fin && !eng_sel,                   // RULE11
                         eng_to, tx_overflow};

    always_comb begin
        state_d = state_q;
        if (i_instr_start) begin
            case (i_instr_code)
                fambm_pkg::INSTR_APPEND:    state_d = fambm_pkg::ST_APPEND;
                fambm_pkg::INSTR_RANDOM:    state_d = fambm_pkg::ST_RANDOM;
                fambm_pkg::INSTR_READ_COPY: state_d = fambm_pkg::ST_COPY_COUNT;
                default:                    state_d = fambm_pkg::ST_IDLE;
            endcase
        end else if (i_instr_end) begin
            state_d = fambm_pkg::ST_IDLE;
        end else if (ccount_byte) begin
            state_d = fambm_pkg::ST_COPY_DATA;
        end
    end

    wire [7:0] resp_d =
        i_instr_start ? status_byte :
        append_byte   ? occupancy :                             // RULE3
        rand_byte     ? rand_value :                            // RULE5
        ccount_byte   ? i_rxq_count :
        copy_take     ? i_rxq_data :                            // RULE13
                        fambm_pkg::EMPTY_READ;
    wire resp_v_d = i_instr_start || append_byte || rand_byte ||
                    ccount_byte || cdata_byte;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_q     <= fambm_pkg::ST_IDLE;
            copy_addr_q <= '0;
        end else begin
            state_q <= state_d;
            if (i_instr_start) begin
                copy_addr_q <= i_copy_addr;
            end else if (copy_take) begin
                copy_addr_q <= copy_addr_q + 12'h001;           // RULE13
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pop_wait_q  <= 1'b0;
            rxq_pop_q   <= 1'b0;
            mem_we_q    <= 1'b0;
            mem_addr_q  <= '0;
            mem_wdata_q <= '0;
        end else begin
            pop_wait_q  <= pop_now;
            rxq_pop_q   <= pop_now;
            mem_we_q    <= pop_now;                             // RULE6
            mem_addr_q  <= mem_addr_d;
            mem_wdata_q <= i_rxq_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            resp_valid_q <= 1'b0;
            resp_data_q  <= fambm_pkg::RESP_RESET;
            remaining_q  <= fambm_pkg::NO_BYTES;
            blocked_q    <= 1'b0;
            exc_q        <= '0;
        end else begin
            resp_valid_q <= resp_v_d;
            resp_data_q  <= resp_d;
            blocked_q    <= blocked_d;
            exc_q        <= exc_d;
            if (eng_fin) begin
                remaining_q <= remaining_d;                     // RULE9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Submodules and outputs

    fambm_fifo #(
        .WIDTH (fambm_pkg::DATA_W),
        .DEPTH (TXQ_DEPTH)
    ) u_txq (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_in_valid  (txq_push),
        .i_in_data   (i_byte_data),
        .o_in_ready  (txq_in_ready),
        .o_out_valid (o_txq_valid),
        .o_out_data  (o_txq_data),
        .i_out_ready (i_txq_ready),
        .o_count     (txq_count)
    );

    fambm_noise_byte u_rand (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_noise_bit (i_noise_bit),
        .o_value     (rand_value)
    );

    assign o_rxq_pop            = rxq_pop_q;
    assign o_mem_we             = mem_we_q;
    assign o_mem_addr           = mem_addr_q;
    assign o_mem_wdata          = mem_wdata_q;
    assign o_resp_valid         = resp_valid_q;
    assign o_resp_data          = resp_data_q;
    assign o_move_remaining     = remaining_q;
    assign o_dpu_blocked        = blocked_q;
    assign o_tx_overflow_exc    = exc_q[0];
    assign o_move_timeout_exc   = exc_q[1];
    assign o_low_prio_done_exc  = exc_q[2];
    assign o_high_prio_done_exc = exc_q[3];
    assign o_slot_busy_exc      = exc_q[4];
    assign o_bad_operand_exc    = exc_q[5];
    assign o_bad_address_exc    = exc_q[6];

endmodule : fambm_core

// ### dv/fambm_core_properties.sv
/*
 * Checker for the interpreter core: response, pop and move exceptions.
 * Assumes it is bound to fambm_core and sees only its ports.
 */
`timescale 1ns/1ns
module fambm_core_checker (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       i_instr_start,
    input wire logic       i_byte_valid,
    input wire logic       i_rxq_valid,
    input wire logic [7:0] i_rxq_data,
    input wire logic       o_rxq_pop,
    input wire logic       o_mem_we,
    input wire logic [7:0] o_mem_wdata,
    input wire logic       o_resp_valid,
    input wire logic [7:0] o_resp_data,
    input wire logic [7:0] o_move_remaining,
    input wire logic       o_dpu_blocked,
    input wire logic       o_move_timeout_exc,
    input wire logic       o_low_prio_done_exc,
    input wire logic       o_high_prio_done_exc
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////////////////
    status_answer_a: assert property (i_instr_start |=> o_resp_valid
        && o_resp_data[7:2] == fambm_pkg::STATUS_PAD)
        else $error("start not answered by status byte");
    resp_cause_a: assert property (o_resp_valid |->
        $past(i_instr_start) || $past(i_byte_valid))
        else $error("response without a request");
    pop_spacing_a: assert property (o_rxq_pop |=> !o_rxq_pop)
        else $error("receive queue popped twice in a row");
    pop_needs_data_a: assert property (o_rxq_pop |-> $past(i_rxq_valid))
        else $error("pop of an empty receive queue");
    wdata_source_a: assert property (o_mem_we |->
        o_mem_wdata == $past(i_rxq_data) && o_rxq_pop)
        else $error("memory data not the popped byte");
    timeout_done_a: assert property (o_move_timeout_exc |->
        o_low_prio_done_exc || o_high_prio_done_exc)
        else $error("timeout without done event");
    timeout_remain_a: assert property (o_move_timeout_exc |->
        o_move_remaining != fambm_pkg::NO_BYTES)
        else $error("timeout with nothing left");
    success_remain_a: assert property ((o_low_prio_done_exc
        || o_high_prio_done_exc) && !o_move_timeout_exc
        |-> o_move_remaining == fambm_pkg::NO_BYTES)
        else $error("finished move leaves a count");
    blocked_low_a: assert property (o_dpu_blocked
        |-> !o_low_prio_done_exc)
        else $error("low move ran while blocked");
endmodule : fambm_core_checker

bind fambm_core fambm_core_checker fambm_core_checker_i (
    .i_clk, .i_reset, .i_instr_start, .i_byte_valid, .i_rxq_valid,
    .i_rxq_data, .o_rxq_pop, .o_mem_we, .o_mem_wdata, .o_resp_valid,
    .o_resp_data, .o_move_remaining, .o_dpu_blocked, .o_move_timeout_exc,
    .o_low_prio_done_exc, .o_high_prio_done_exc
);

// ### dv/fambm_rxq_model.sv
/*
 * Receive queue model: bench pushes bytes, core pops the head.
 * Assumes pops advance the head at the next edge; stall hides the head.
 */
`timescale 1ns/1ns
module fambm_rxq_model (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_push,
    input  wire logic [7:0] i_push_data,
    input  wire logic       i_stall,
    input  wire logic       i_pop,
    output logic            o_valid,
    output logic [7:0]      o_data,
    output logic [7:0]      o_count
);
    logic [7:0] q[$];
    logic [7:0] last_q = 8'h00;
    logic [7:0] head_q = 8'h00;
    logic [7:0] size_q = 8'h00;
    // Size and head change only after the edge, as a real queue's flops would; i_stall masks the outputs at once
    always @(posedge i_clk) begin
        if (i_reset) begin
            q.delete();
        end else begin
            if (i_pop && q.size() != 0) begin
                last_q <= q.pop_front();
            end
            if (i_push) begin
                q.push_back(i_push_data);
            end
        end
        size_q <= 8'(q.size());
        head_q <= (q.size() != 0) ? q[0] : 8'h00;
    end
    always_comb begin
        o_valid = (size_q != 8'h00) && !i_stall;
        o_data  = o_valid ? head_q : ~last_q;
        o_count = i_stall ? 8'h00 : size_q;
    end
endmodule : fambm_rxq_model

// ### dv/fambm_core_tb.sv
/*
 * Self-checking bench for fambm_core with a receive queue model.
 * Assumes the design's default memory limit and transmit depth.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module fambm_core_tb;
    logic i_clk = 0, i_reset = 1, st = 0, en = 0, bv = 0, pr = 0;
    logic [1:0] code = 0;
    logic [7:0] bd = 0, cnt = 0, rxd, rxc, d;
    logic [11:0] ma = 0, ca = 0;
    logic ctrl = 0, fd = 0, nb = 0, rxv, pop, push = 0, stall = 0, txr = 0;
    logic [7:0] pd = 0;
    logic txv, we, rv, blk;
    logic [7:0] txd, wd, rd, rem;
    logic [11:0] wa;
    wire [6:0] x;
    logic [8:0] rq[$], e;
    logic [19:0] mq[$], m;
    logic [7:0] tq[$];
    int xc[7], err_count = 0, num_checks = 0, cyc = 0, seed = 32'h53bb;
    always #10 i_clk = ~i_clk;
    fambm_core fambm_core_i (.i_clk, .i_reset, .i_instr_start(st),
        .i_instr_code(code), .i_instr_end(en), .i_byte_valid(bv),
        .i_byte_data(bd), .i_move_prio(pr), .i_move_addr(ma),
        .i_move_count(cnt), .i_copy_addr(ca), .i_rx_timeout_ctrl(ctrl),
        .i_frame_done(fd), .i_noise_bit(nb), .i_rxq_valid(rxv),
        .i_rxq_data(rxd), .i_rxq_count(rxc), .o_rxq_pop(pop),
        .o_txq_valid(txv), .o_txq_data(txd), .i_txq_ready(txr),
        .o_mem_we(we), .o_mem_addr(wa), .o_mem_wdata(wd),
        .o_resp_valid(rv), .o_resp_data(rd), .o_move_remaining(rem),
        .o_dpu_blocked(blk), .o_tx_overflow_exc(x[0]),
        .o_move_timeout_exc(x[1]), .o_low_prio_done_exc(x[2]),
        .o_high_prio_done_exc(x[3]), .o_slot_busy_exc(x[4]),
        .o_bad_operand_exc(x[5]), .o_bad_address_exc(x[6]));
    fambm_rxq_model fambm_rxq_model_i (.i_clk, .i_reset, .i_push(push),
        .i_push_data(pd), .i_stall(stall), .i_pop(pop), .o_valid(rxv),
        .o_data(rxd), .o_count(rxc));
    ////////////////////////////////////////////////////////////////////////
    // Monitors: responses, memory writes, exception pulses, hang guard
    always @(posedge i_clk) begin
        nb <= 1'($random(seed));
        for (int i = 0; i < 7; i++) xc[i] += (x[i] === 1'b1);
        if (rv === 1'b1) begin
            e = rq.pop_front();
            if (!e[8]) `CHK(rd, e[7:0])
        end
        if (we === 1'b1) begin
            m = mq.pop_front();
            `CHK({wa, wd}, m)
        end
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // Strobe select: 0 start, 1 byte, 2 end, 3 receive queue push
    task automatic pulse(int w);
        @(posedge i_clk) {st, bv, en, push} <= 4'b1000 >> w;
        @(posedge i_clk) {st, bv, en, push} <= 4'h0;
    endtask : pulse
    task automatic start(logic [1:0] c, logic p, logic [11:0] a,
                         logic [7:0] n, logic t, logic [8:0] s);
        rq.push_back(s);
        code <= c; pr <= p; ma <= a; ca <= a; cnt <= n; ctrl <= t;
        pulse(0);
    endtask : start
    task automatic snd(logic [8:0] s);
        rq.push_back(s);
        bd <= 8'($random(seed));
        pulse(1);
    endtask : snd
    task automatic mv(logic p, logic [11:0] a, logic [7:0] n, logic t,
                      logic [8:0] s);
        start(2'h2, p, a, n, t, s);
        pulse(2);
    endtask : mv
    task automatic qpush(logic [11:0] a);
        pd <= 8'($random(seed));
        pulse(3);
        if (a != 0) mq.push_back({a, pd});
    endtask : qpush
    task automatic settle();
        for (int k = 0; k < 100 && mq.size() != 0; k++) @(posedge i_clk);
        repeat (4) @(posedge i_clk);
    endtask : settle
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge i_clk);
        i_reset <= 0;
        start(2'h0, 0, 0, 0, 0, 9'h000);
        for (int i = 0; i < 9; i++) begin
            snd({1'b0, 8'(i)});
            if (i < 8) tq.push_back(bd);
        end
        pulse(2);
        settle();
        `CHK(xc[0], 1)
        @(posedge i_clk) txr <= 1;
        for (int i = 0; i < 8; i++) begin
            @(negedge i_clk) `CHK({txv, txd}, {1'b1, tq[i]})
        end
        @(posedge i_clk) txr <= 0;
        start(2'h1, 0, 0, 0, 0, 9'h000);
        repeat (3) snd(9'h100);
        pulse(2);
        @(posedge i_clk) stall <= 1;
        mv(0, 12'h100, 2, 1, 9'h000);
        mv(1, 12'h200, 2, 1, 9'h001);
        @(negedge i_clk) `CHK(blk, 1'b1)
        mv(0, 12'h100, 2, 1, 9'h003);
        for (int i = 0; i < 4; i++) qpush(12'(i < 2 ? 'h200 + i : 'h0fe + i));
        @(posedge i_clk) stall <= 0;
        settle();
        `CHK({xc[4], xc[3], xc[2]}, {32'd1, 32'd1, 32'd1})
        `CHK(rem, 8'h00)
        @(posedge i_clk) stall <= 1;
        mv(1, 12'h200, 2, 0, 9'h000);
        settle();
        `CHK({xc[1], xc[3], rem}, {32'd1, 32'd2, 8'h02})
        mv(0, 12'h100, 0, 0, 9'h000);
        mv(0, 12'hfff, 2, 0, 9'h000);
        settle();
        `CHK({xc[5], xc[6], xc[2]}, {32'd1, 32'd1, 32'd1})
        qpush(12'h180);
        mv(0, 12'h180, 4, 1, 9'h000);
        @(posedge i_clk) begin stall <= 0; fd <= 1; end
        settle();
        `CHK({xc[1], xc[2], rem}, {32'd2, 32'd2, 8'h03})
        @(posedge i_clk) fd <= 0;
        qpush(12'h300);
        qpush(12'h301);
        d = mq[1][7:0];
        start(2'h3, 0, 12'h300, 0, 0, 9'h000);
        snd(9'h002);
        @(posedge i_clk);
        snd({1'b0, mq[0][7:0]});
        @(posedge i_clk);
        snd({1'b0, d});
        pulse(2);
        settle();
        `CHK({rq.size() == 0, mq.size() == 0}, 2'b11)
        end_sim();
    end
endmodule : fambm_core_tb
